// >>> src/hsw_pkg.sv
// package for the hdlc send-and-wait command executor
// assumes a single 40 MHz clock domain and an apb register bus
package hsw_pkg;
    // -------------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_STATION = 8'h08;
    localparam logic [7:0] OFS_SEQ = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_LEN = 8'h14;
    localparam logic [7:0] OFS_RXFLD = 8'h18;
    localparam logic [7:0] OFS_KEY = 8'h1C;
    localparam logic [7:0] OFS_DPTR = 8'h20;
    localparam logic [7:0] OFS_TRGST = 8'h24;
    // -------------------------------------------------------------------
    // command word layout
    // -------------------------------------------------------------------
    localparam int CMD_FLD_LSB = 28;
    localparam int SUB_FLD_LSB = 24;
    localparam logic [3:0] CMD_SEND = 4'h1;
    localparam logic [3:0] CMD_WAIT = 4'h2;
    localparam logic [3:0] SUB_FRM = 4'h6;
    localparam logic [3:0] SUB_WCHR = 4'h0;
    localparam logic [3:0] SUB_WFRM = 4'h1;
    localparam logic [3:0] SUB_WTRG = 4'h2;
    localparam logic [3:0] SUB_WTM = 4'h3;
    localparam logic [3:0] SUB_WKEY = 4'h4;
    localparam logic [3:0] TYPE_USER_DATA_FRAME_TYPE = 4'h0;
    localparam logic [3:0] TYPE_MAX = 4'h9;
    localparam logic [7:0] TBL_MAX = 8'h9F;
    localparam logic [7:0] TBL_NONE = 8'hFF;
    localparam logic [7:0] ADDR_A = 8'h01;
    localparam logic [7:0] ADDR_B = 8'h03;
    localparam logic [7:0] DATA_OFS = 8'h02;
    localparam logic [31:0] KEY_BREAK = 32'h0098967F;
    localparam logic [31:0] CFG_RST = 32'h00000000;
    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int MS_UNIT = 1;
    localparam logic [15:0] MS_CYC = 16'(CLK_HZ / 1000 * MS_UNIT - 1);
    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEND = 3'b001,
        ST_WCHR = 3'b010,
        ST_WFRM = 3'b011,
        ST_WTRG = 3'b100,
        ST_WTM = 3'b101,
        ST_WKEY = 3'b110
    } hsw_state_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] ctrl;
        logic [7:0] tbl;
        logic has_user_data_frame_type;
        logic fcs_en;
    } hsw_txreq_s;
    typedef struct packed {
        logic [7:0] data;
        logic eof;
        logic err;
    } hsw_rxbyte_s;
endpackage : hsw_pkg

// >>> src/hsw_exec.sv
// hdlc frame-send and wait command executor with apb registers
// assumes synchronous inputs, frame transmitter and receiver outside
//
// Contract
// - frame send is cmd 1 sub 6 with frame type 0-9, table 00-9F
// - frame send only transmits when protocol is hdlc
// - address from station value; control from type, V(S), V(R), P/F
// - user_data_frame_type from chosen table; don't-care table sends no user_data_frame_type field
// - fcs appended by transmitter unless fcs setting is none
// - new frame waits for busy line; sequencer does not await end
// - user-data frame increments V(S), wrapped by modulo
// - break input ends any wait immediately
// - cmd 2 sub 0 waits for up to 8 char pattern with wildcards
// - don't-care pattern ends on any char, frame buffer untouched
// - cmd 2 sub 1 waits for one whole frame and stores it
// - frame buffer holds until the next frame-wait command
// - length counts data incl fcs; zero when wait interrupted
// - good hdlc frame loads address, P/F, N(S), N(R) fields
// - user-data frame to 01H/03H with N(S)=V(R) increments V(R)
// - data pointer is user_data_frame_type offset for good frame, else zero
// - cmd 2 sub 2 waits on trigger 1-3; trigger 0 rejected
// - trigger wait releases only on unsatisfied-to-satisfied edge
// - cmd 2 sub 3 waits count of 1 ms units
// - cmd 2 sub 4 waits for any key 0-F
// - key value stores key, or 9999999 when interrupted
`timescale 1ns/1ps
`default_nettype none
module hsw_exec (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // transmitter side
    output hsw_pkg::hsw_txreq_s TX_REQ_O,
    output logic TX_START_O,
    input wire logic TX_BUSY_I,
    // receiver side
    input wire logic RX_VALID_I,
    input wire hsw_pkg::hsw_rxbyte_s RX_BYTE_I,
    // events
    input wire logic BREAK_I,
    input wire logic [3:1] TRIG_I,
    input wire logic KEY_VALID_I,
    input wire logic [3:0] KEY_NUM_I,
    // frame buffer read port and sequencer busy flag
    input wire logic [7:0] FB_ADDR_I,
    output logic [7:0] FB_DATA_O,
    output logic BUSY_O
);
    import hsw_pkg::*;

    // ----------------
    // functions
    // ----------------
    // pattern byte match: bit 9 wildcard, bit 8 flag
    function automatic logic pat_hit(input logic [9:0] p,
                                     input logic [7:0] d);
        pat_hit = p[9] | (!p[8] & (p[7:0] == d));
    endfunction : pat_hit

    // modulo wrap: cfg bit set selects modulo 128, else 8
    function automatic logic [6:0] seq_inc(input logic [6:0] v,
                                           input logic m128);
        logic [6:0] n;
        n = v + 7'h01;
        seq_inc = m128 ? n : {4'h0, n[2:0]};
    endfunction : seq_inc

    // ----------------
    // registers
    // ----------------
    hsw_state_e state_q;
    logic [31:0] cmd_q;
    logic [79:0] pat_q;
    logic [3:0] pat_len_q;
    logic [31:0] cfg_q;
    logic [7:0] station_q;
    logic [6:0] vs_q;
    logic [6:0] vr_q;
    logic pf_q;
    logic [15:0] len_q;
    logic [15:0] len_cnt_q;
    logic [7:0] rx_addr_q;
    logic [6:0] rx_ns_q;
    logic [6:0] rx_nr_q;
    logic rx_pf_q;
    logic [31:0] key_q;
    logic [7:0] dptr_q;
    logic [3:0] pat_pos_q;
    logic [19:0] ms_left_q;
    logic [15:0] ms_div_q;
    logic [3:1] trg_prev_q;
    logic bad_cmd_q;
    logic [7:0] fb_mem [0:255];
    logic [7:0] fb_wa_q;
    logic rx_err_q;
    logic [7:0] rx_ctrl_q;

    // config fields: bit0 hdlc, bit1 fcs enabled, bit2 modulo 128
    logic cfg_hdlc;
    logic cfg_fcs;
    logic cfg_m128;
    assign cfg_hdlc = cfg_q[0];
    assign cfg_fcs = cfg_q[1];
    assign cfg_m128 = cfg_q[2];

    // command fields
    logic [3:0] c_cmd;
    logic [3:0] c_sub;
    logic [3:0] c_type;
    logic [7:0] c_tbl;
    logic [19:0] c_ms;
    logic [1:0] c_trg;
    assign c_cmd = cmd_q[CMD_FLD_LSB +: 4];
    assign c_sub = cmd_q[SUB_FLD_LSB +: 4];
    assign c_type = cmd_q[11:8];
    assign c_tbl = cmd_q[7:0];
    assign c_ms = cmd_q[19:0];
    assign c_trg = cmd_q[1:0];

    logic apb_wr;
    logic apb_rd;
    assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
    assign apb_rd = PSEL_I & !PENABLE_I & !PWRITE_I;

    logic idle;
    assign idle = (state_q == ST_IDLE);
    logic cmd_wr;
    assign cmd_wr = apb_wr & (PADDR_I == OFS_CMD) & idle;
    logic go_q;

    // pattern byte currently awaited
    logic [9:0] pat_cur;
    assign pat_cur = pat_q[pat_pos_q * 10 +: 10];
    logic ctl_ns;
    logic ctl_nr;
    // user_data_frame_type frames carry N(S); user_data_frame_type and supervisory carry N(R)
    assign ctl_ns = !rx_ctrl_q[0];
    assign ctl_nr = !(rx_ctrl_q[0] & rx_ctrl_q[1]);

    // ----------------
    // apb slave: zero wait, unmapped reads zero with error
    // ----------------
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PRDATA_O <= 32'h00000000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I & !PENABLE_I;
            PSLVERR_O <= 1'b0;
            if (apb_rd) begin
                case (PADDR_I)
                    OFS_CMD: PRDATA_O <= cmd_q;
                    OFS_CFG: PRDATA_O <= cfg_q;
                    OFS_STATION: PRDATA_O <= {24'h000000, station_q};
                    OFS_SEQ: PRDATA_O <= {15'h0000, pf_q, 1'b0, vr_q,
                                          1'b0, vs_q};
                    OFS_STATUS: PRDATA_O <= {27'h0000000, bad_cmd_q,
                                             !idle, state_q[2:0]};
                    OFS_LEN: PRDATA_O <= {16'h0000, len_q};
                    OFS_RXFLD: PRDATA_O <= {8'h00, rx_pf_q, rx_nr_q,
                                            1'b0, rx_ns_q, rx_addr_q};
                    OFS_KEY: PRDATA_O <= key_q;
                    OFS_DPTR: PRDATA_O <= {24'h000000, dptr_q};
                    OFS_TRGST: PRDATA_O <= {28'h0000000, TRIG_I, 1'b0};
                    default: begin
                        PRDATA_O <= 32'h00000000;
                        PSLVERR_O <= PSEL_I;
                    end
                endcase
            end
        end
    end

    // ----------------
    // software settings: config, station, sequence loads, pattern
    // ----------------
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cfg_q <= CFG_RST;
            station_q <= 8'h00;
            pf_q <= 1'b0;
            pat_q <= '0;
            pat_len_q <= 4'h0;
        end else if (apb_wr) begin
            case (PADDR_I)
                OFS_CFG: cfg_q <= PWDATA_I;
                OFS_STATION: station_q <= PWDATA_I[7:0];
                OFS_SEQ: pf_q <= PWDATA_I[16];
                // pattern entries pushed 10 bits at a time
                OFS_TRGST: begin
                    pat_q <= {pat_q[69:0], PWDATA_I[9:0]};
                    pat_len_q <= PWDATA_I[19:16];
                end
                default: ;
            endcase
        end
    end

    // ----------------
    // sequencer state machine
    // ----------------
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            cmd_q <= 32'h00000000;
            go_q <= 1'b0;
            bad_cmd_q <= 1'b0;
            TX_START_O <= 1'b0;
            TX_REQ_O <= '0;
            BUSY_O <= 1'b0;
        end else begin
            TX_START_O <= 1'b0;
            go_q <= cmd_wr;
            BUSY_O <= !idle | go_q;
            if (cmd_wr) begin
                cmd_q <= PWDATA_I;
            end
            case (state_q)
                ST_IDLE: if (go_q) begin
                    bad_cmd_q <= 1'b0;
                    if (c_cmd == CMD_SEND && c_sub == SUB_FRM) begin
                        if (cfg_hdlc && c_type <= TYPE_MAX &&
                            (c_tbl <= TBL_MAX || c_tbl == TBL_NONE)) begin
                            state_q <= ST_SEND;
                        end else begin
                            bad_cmd_q <= 1'b1;
                        end
                    end else if (c_cmd == CMD_WAIT) begin
                        case (c_sub)
                            SUB_WCHR: state_q <= ST_WCHR;
                            SUB_WFRM: state_q <= ST_WFRM;
                            SUB_WTRG: begin
                                if (c_trg == 2'b00) begin
                                    bad_cmd_q <= 1'b1;
                                end else begin
                                    state_q <= ST_WTRG;
                                end
                            end
                            SUB_WTM: state_q <= ST_WTM;
                            SUB_WKEY: state_q <= ST_WKEY;
                            default: bad_cmd_q <= 1'b1;
                        endcase
                    end else begin
                        bad_cmd_q <= 1'b1;
                    end
                end
                ST_SEND: if (!TX_BUSY_I) begin
                    TX_REQ_O.addr <= station_q;
                    // user data carries N(S) from V(S), low bit zero
                    TX_REQ_O.ctrl <= (c_type == TYPE_USER_DATA_FRAME_TYPE) ?
                        {vr_q[2:0], pf_q, vs_q[2:0], 1'b0} :
                        {vr_q[2:0], pf_q, c_type};
                    TX_REQ_O.tbl <= c_tbl;
                    TX_REQ_O.has_user_data_frame_type <= (c_tbl != TBL_NONE);
                    TX_REQ_O.fcs_en <= cfg_fcs;
                    TX_START_O <= 1'b1;
                    state_q <= ST_IDLE;
                end
                ST_WCHR, ST_WFRM, ST_WTRG, ST_WKEY: begin
                    if (BREAK_I) begin
                        state_q <= ST_IDLE;
                    end else if (
                        (state_q == ST_WCHR && RX_VALID_I &&
                         pat_hit(pat_cur, RX_BYTE_I.data) &&
                         pat_pos_q + 4'h1 >= pat_len_q) ||
                        (state_q == ST_WFRM && RX_VALID_I &&
                         RX_BYTE_I.eof) ||
                        (state_q == ST_WTRG &&
                         TRIG_I[c_trg] && !trg_prev_q[c_trg]) ||
                        (state_q == ST_WKEY && KEY_VALID_I)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_WTM: begin
                    if (BREAK_I || ms_left_q == 20'h00000) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------
    // send-sequence variable V(S)
    // ----------------
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            vs_q <= 7'h00;
        end else if (apb_wr && PADDR_I == OFS_SEQ) begin
            vs_q <= PWDATA_I[6:0];
        end else if (state_q == ST_SEND && !TX_BUSY_I &&
                     c_type == TYPE_USER_DATA_FRAME_TYPE) begin
            vs_q <= seq_inc(vs_q, cfg_m128);
        end
    end

    // ----------------
    // character pattern matcher and timers
    // ----------------
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pat_pos_q <= 4'h0;
            ms_left_q <= 20'h00000;
            ms_div_q <= 16'h0000;
            trg_prev_q <= 3'b000;
        end else begin
            trg_prev_q <= TRIG_I;
            if (state_q != ST_WCHR) begin
                pat_pos_q <= 4'h0;
            end else if (RX_VALID_I) begin
                // wildcard-only pattern ends on any char
                pat_pos_q <= pat_hit(pat_cur, RX_BYTE_I.data) ?
                             pat_pos_q + 4'h1 : 4'h0;
            end
            if (state_q != ST_WTM) begin
                ms_left_q <= c_ms;
                ms_div_q <= MS_CYC;
            end else if (ms_div_q == 16'h0000) begin
                ms_div_q <= MS_CYC;
                ms_left_q <= ms_left_q - 20'h00001;
            end else begin
                ms_div_q <= ms_div_q - 16'h0001;
            end
        end
    end

    // ----------------
    // frame buffer capture (only during frame wait)
    // ----------------
    always_ff @(posedge REF_CLK_I) begin
        if (state_q == ST_WFRM && RX_VALID_I) begin
            fb_mem[fb_wa_q] <= RX_BYTE_I.data;
        end
        FB_DATA_O <= fb_mem[FB_ADDR_I];
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fb_wa_q <= 8'h00;
            len_cnt_q <= 16'h0000;
            rx_err_q <= 1'b0;
            rx_ctrl_q <= 8'h00;
        end else if (state_q != ST_WFRM) begin
            fb_wa_q <= 8'h00;
            len_cnt_q <= 16'h0000;
            rx_err_q <= 1'b0;
        end else if (RX_VALID_I) begin
            fb_wa_q <= fb_wa_q + 8'h01;
            len_cnt_q <= len_cnt_q + 16'h0001;
            rx_err_q <= rx_err_q | RX_BYTE_I.err;
            if (fb_wa_q == 8'h01) begin
                rx_ctrl_q <= RX_BYTE_I.data;
            end
        end
    end

    // ----------------
    // result variables after frame wait
    // ----------------
    logic frm_done;
    logic frm_good;
    assign frm_done = state_q == ST_WFRM && !BREAK_I && RX_VALID_I &&
                      RX_BYTE_I.eof;
    assign frm_good = frm_done && cfg_hdlc && !rx_err_q &&
                      !RX_BYTE_I.err && fb_wa_q >= 8'h02;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            len_q <= 16'h0000;
            rx_addr_q <= 8'h00;
            rx_ns_q <= 7'h00;
            rx_nr_q <= 7'h00;
            rx_pf_q <= 1'b0;
            dptr_q <= 8'h00;
            vr_q <= 7'h00;
        end else begin
            if (state_q == ST_WFRM && BREAK_I) begin
                len_q <= 16'h0000;
                dptr_q <= 8'h00;
            end else if (frm_done) begin
                len_q <= len_cnt_q + 16'h0001;
                dptr_q <= frm_good ? DATA_OFS : 8'h00;
            end
            if (frm_good) begin
                rx_addr_q <= fb_mem[0];
                rx_pf_q <= rx_ctrl_q[4];
                if (ctl_ns) begin
                    rx_ns_q <= {4'h0, rx_ctrl_q[3:1]};
                end
                if (ctl_nr) begin
                    rx_nr_q <= {4'h0, rx_ctrl_q[7:5]};
                end
            end
            if (apb_wr && PADDR_I == OFS_SEQ) begin
                vr_q <= PWDATA_I[14:8];
            end else if (frm_good && ctl_ns &&
                         (fb_mem[0] == ADDR_A || fb_mem[0] == ADDR_B) &&
                         {4'h0, rx_ctrl_q[3:1]} == vr_q) begin
                vr_q <= seq_inc(vr_q, cfg_m128);
            end
        end
    end

    // ----------------
    // key value
    // ----------------
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            key_q <= 32'h00000000;
        end else if (state_q == ST_WKEY) begin
            if (BREAK_I) begin
                key_q <= KEY_BREAK;
            end else if (KEY_VALID_I) begin
                key_q <= {28'h0000000, KEY_NUM_I};
            end
        end
    end
endmodule : hsw_exec
`default_nettype wire

// >>> dv/hsw_exec_assertions.sv
// checker for the send-and-wait executor ports
// assumes one clock domain, bound onto hsw_exec
`timescale 1ns/1ps
`default_nettype none
module hsw_exec_assertions
import hsw_pkg::*;
(
    // clock, reset and bus
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // transmit, events and sequencer busy
    input wire hsw_pkg::hsw_txreq_s TX_REQ_O,
    input wire logic TX_START_O,
    input wire logic TX_BUSY_I,
    input wire logic BREAK_I,
    input wire logic BUSY_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ------------------------------------------------------------
    // bus and launch relations
    // ------------------------------------------------------------
    bus_answer_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no answer after setup");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    err_read_a: assert property (PSLVERR_O |-> PREADY_O && !PWRITE_I)
        else $error("error outside a read answer");
    start_pulse_a: assert property (TX_START_O |=> !TX_START_O)
        else $error("launch longer than one cycle");
    start_free_a: assert property (TX_START_O |-> !$past(TX_BUSY_I))
        else $error("launch while line busy");
    table_range_a: assert property (TX_START_O |->
        TX_REQ_O.tbl <= TBL_MAX || TX_REQ_O.tbl == TBL_NONE)
        else $error("table number out of range");
    user_data_frame_type_flag_a: assert property (TX_START_O |->
        TX_REQ_O.has_user_data_frame_type == (TX_REQ_O.tbl != TBL_NONE))
        else $error("user_data_frame_type flag disagrees with table");
    no_await_a: assert property (TX_START_O |-> ##[1:3] !BUSY_O)
        else $error("sequencer waits for frame end");
    break_stop_a: assert property ($rose(BREAK_I) && BUSY_O && !TX_BUSY_I
        |-> ##[1:3] !BUSY_O)
        else $error("wait not ended by break");
    cover property (TX_START_O);
    cover property (PSLVERR_O);
    cover property ($rose(BREAK_I) && BUSY_O);
endmodule : hsw_exec_assertions
bind hsw_exec hsw_exec_assertions chk_u (.REF_CLK_I(REF_CLK_I),
    .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .TX_REQ_O(TX_REQ_O), .TX_START_O(TX_START_O), .TX_BUSY_I(TX_BUSY_I),
    .BREAK_I(BREAK_I), .BUSY_O(BUSY_O));
`default_nettype wire

// >>> dv/hsw_station_model.sv
// far-side station: transmitter busy line and byte receiver
// assumes bench calls rx_put just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module hsw_station_model
import hsw_pkg::*;
#(parameter int BUSY_CYC = 20)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // line side
    input wire logic tx_start_i,
    output logic tx_busy_o,
    output logic rx_valid_o,
    output hsw_pkg::hsw_rxbyte_s rx_byte_o
);
    int cnt_q;
    // line stays busy a fixed span after each launch
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_q <= 0;
        else if (tx_start_i) cnt_q <= BUSY_CYC;
        else if (cnt_q > 0) cnt_q <= cnt_q - 1;
    end
    assign tx_busy_o = (cnt_q > 0);
    initial rx_valid_o = 1'b0;
    initial rx_byte_o = '0;
    // one byte; stale lines show the inverse afterwards
    task automatic rx_put(input logic [7:0] d, input logic eof);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_byte_o <= {d, eof, 1'b0};
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_byte_o <= {~d, ~eof, 1'b1};
    endtask : rx_put
endmodule : hsw_station_model
`default_nettype wire

// >>> dv/hsw_exec_bench.sv
// self-checking bench for the send-and-wait executor
// assumes the station model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module hsw_exec_bench;
    import hsw_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0, st, tb;
    logic [31:0] pwdata = '0, prdata, lfsr_q = 32'h8C81BABD;
    logic pready, pslverr, tx_start, tx_busy, rx_valid, busy;
    logic brk = 0, key_valid = 0;
    logic [3:1] trig = '0;
    logic [3:0] key_num = '0;
    hsw_txreq_s txreq;
    hsw_rxbyte_s rx_byte;
    logic [32:0] rdq[$], txq[$];
    int err_total = 0, samples_checked = 0;
    hsw_exec dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .TX_REQ_O(txreq), .TX_START_O(tx_start),
        .TX_BUSY_I(tx_busy), .RX_VALID_I(rx_valid), .RX_BYTE_I(rx_byte),
        .BREAK_I(brk), .TRIG_I(trig), .KEY_VALID_I(key_valid),
        .KEY_NUM_I(key_num), .FB_ADDR_I(8'h00), .FB_DATA_O(),
        .BUSY_O(busy));
    hsw_station_model station_u (.clk_i(clk), .rst_n_i(rst_n),
        .tx_start_i(tx_start), .tx_busy_o(tx_busy),
        .rx_valid_o(rx_valid), .rx_byte_o(rx_byte));
    // ------------------------------------------------------------
    // clock, watchdog and helpers
    // ------------------------------------------------------------
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        end_sim();
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    task automatic check(input string nm, input logic [32:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (!pready && ++n < 20);
        check("pready", {32'h0, pready}, 33'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rdq.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic cmd(input logic [3:0] c, s, input logic [23:0] op);
        apb(1'b1, OFS_CMD, {c, s, op});
    endtask : cmd
    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0 && n++ < lim) @(posedge clk);
        check("idle", {32'h0, busy}, 33'h0);
    endtask : wait_idle
    task automatic pulse_break;
        repeat (5) @(posedge clk);
        brk <= 1'b1;
        @(posedge clk);
        brk <= 1'b0;
        wait_idle(50);
    endtask : pulse_break
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    // result watcher: read data and frame launches
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite)
            check("rdata", {pslverr, prdata}, rdq.pop_front());
        if (tx_start && txq.size() == 0)
            check("start", 33'h1, 33'h0);
        else if (tx_start)
            check("txreq", {7'h0, txreq.ctrl, txreq.addr, txreq.tbl,
                txreq.has_user_data_frame_type,
                txreq.fcs_en}, txq.pop_front());
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CFG, {1'b0, CFG_RST});
        rd(8'h40, 33'h1_0000_0000);
        $display("test map done");
        lfsr_q = lfsr_next(lfsr_q);
        st = lfsr_q[7:0];
        tb = 8'(lfsr_q[15:8] % 8'hA0);
        apb(1'b1, OFS_CFG, 32'h3);
        apb(1'b1, OFS_STATION, {24'h0, st});
        apb(1'b1, OFS_SEQ, 32'h0001_0007);
        txq.push_back({7'h0, 8'h1E, st, tb, 2'b11});
        cmd(CMD_SEND, SUB_FRM, {12'h0, TYPE_USER_DATA_FRAME_TYPE, tb});
        wait_idle(50);
        txq.push_back({7'h0, 8'h19, st, TBL_NONE, 2'b01});
        cmd(CMD_SEND, SUB_FRM, {12'h0, TYPE_MAX, TBL_NONE});
        wait_idle(100);
        rd(OFS_SEQ, {1'b0, 32'h0001_0000});
        apb(1'b1, OFS_CFG, 32'h0);
        cmd(CMD_SEND, SUB_FRM, {12'h0, TYPE_USER_DATA_FRAME_TYPE, tb});
        wait_idle(50);
        rd(OFS_SEQ, {1'b0, 32'h0001_0000});
        $display("test send done");
        cmd(CMD_WAIT, SUB_WKEY, 24'h0);
        repeat (5) @(posedge clk);
        key_num <= 4'hF;
        key_valid <= 1'b1;
        @(posedge clk);
        key_valid <= 1'b0;
        wait_idle(50);
        rd(OFS_KEY, 33'h0F);
        cmd(CMD_WAIT, SUB_WKEY, 24'h0);
        pulse_break();
        rd(OFS_KEY, {1'b0, KEY_BREAK});
        $display("test key done");
        apb(1'b1, OFS_CFG, 32'h1);
        cmd(CMD_WAIT, SUB_WFRM, 24'h0);
        station_u.rx_put(ADDR_A, 1'b0);
        station_u.rx_put(8'h00, 1'b0);
        station_u.rx_put(8'hAA, 1'b0);
        station_u.rx_put(8'hBB, 1'b1);
        wait_idle(50);
        rd(OFS_LEN, 33'h4);
        rd(OFS_DPTR, {25'h0, DATA_OFS});
        rd(OFS_SEQ, {1'b0, 32'h0001_0100});
        cmd(CMD_WAIT, SUB_WFRM, 24'h1);
        pulse_break();
        rd(OFS_LEN, 33'h0);
        rd(OFS_DPTR, 33'h0);
        apb(1'b1, OFS_TRGST, 32'h0001_0200);
        cmd(CMD_WAIT, SUB_WCHR, 24'h0);
        station_u.rx_put(8'h5A, 1'b0);
        wait_idle(20);
        $display("test frame done");
        trig <= 3'b001;
        cmd(CMD_WAIT, SUB_WTRG, 24'h1);
        repeat (10) @(posedge clk);
        check("trg_hold", {32'h0, busy}, 33'h1);
        trig <= 3'b000;
        @(posedge clk);
        trig <= 3'b001;
        wait_idle(20);
        cmd(CMD_WAIT, SUB_WTRG, 24'h0);
        repeat (4) @(posedge clk);
        check("trg_zero", {32'h0, busy}, 33'h0);
        cmd(CMD_WAIT, SUB_WTM, 24'h1);
        repeat (39990) @(posedge clk);
        check("timer", {32'h0, busy}, 33'h1);
        wait_idle(100);
        $display("test trigger and timer done");
        end_sim();
    end
endmodule : hsw_exec_bench
`default_nettype wire
